// [core/btms_core.sv]
// btms_core: test mode selection and xor connectivity chains
// assumes: clk is the pci clock; pads fed by padOut/padOe, read via padIn
`timescale 1ns/10ps
module btms_core
  import btms_pkg::*;
#(
  parameter int NPINS = btms_pkg::NUM_PINS,
  parameter logic [btms_pkg::NUM_CHAINS-1:0][btms_pkg::NUM_PINS-1:0]
    CHAIN_MASK = {64'h0000_00FF_0000_0000, 64'h00FF_0000_0000_0000,
                  64'h0000_0000_FF00_0000, 64'h0000_0000_00FF_0000,
                  64'h0000_0000_0000_FF00, 64'h0000_0000_0000_00FF},
  parameter logic [btms_pkg::NUM_CHAINS-1:0][btms_pkg::PIN_IDX_W-1:0]
    CHAIN_OUT = {6'h28, 6'h38, 6'h20, 6'h18, 6'h10, 6'h08}
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              rtc_domain_reset_n,
  input  wire logic              core_power_good,
  input  wire logic              host_bus_reset_out_n,
  input  wire logic [NPINS-1:0]  padIn,
  input  wire logic [NPINS-1:0]  coreOut,
  input  wire logic [NPINS-1:0]  coreOe,
  output logic      [NPINS-1:0]  padOut,
  output logic      [NPINS-1:0]  padOe,
  output btms_pkg::btms_mode_t   testMode,
  output logic                   test_point_zero
);
  import btms_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic             rtcMeta;
  logic             rtcSync;
  logic             rtcPrev;
  logic             pgMeta;
  logic             pgSync;
  logic [NPINS-1:0] padMeta;
  logic [NPINS-1:0] padSync;
  logic [CNT_W-1:0] lowCount;
  logic [CNT_W-1:0] next_lowCount;
  btms_sel_t        sel;
  logic             rtcRise;
  logic             countEn;
  logic [NUM_CHAINS-1:0] parity;
  logic [NPINS-1:0] outOneHot;

  // reset pin and power good, two stages each
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtcMeta <= 1'b1;
      rtcSync <= 1'b1;
      rtcPrev <= 1'b1;
      pgMeta  <= 1'b0;
      pgSync  <= 1'b0;
    end
    else
    begin
      rtcMeta <= rtc_domain_reset_n;
      rtcSync <= rtcMeta;
      rtcPrev <= rtcSync;
      pgMeta  <= core_power_good;
      pgSync  <= pgMeta;
    end
  end

  // chain input pins, two stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padMeta <= '0;
      padSync <= '0;
    end
    else
    begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // ----------------------------------------------------------------
  // low-time counter
  // ----------------------------------------------------------------
  assign rtcRise = rtcSync & ~rtcPrev;
  // count only once bus reset is released
  assign countEn = pgSync & ~rtcSync & host_bus_reset_out_n;

  // clear on power loss or rise, saturate at ceiling
  always_comb
  begin
    next_lowCount = lowCount;
    if (!pgSync || rtcRise)
      next_lowCount = CNT_RST;
    else if (countEn && lowCount != CNT_MAX)
      next_lowCount = lowCount + 6'h01;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lowCount <= CNT_RST;
    else
      lowCount <= next_lowCount;
  end

  // ----------------------------------------------------------------
  // mode latch
  // ----------------------------------------------------------------
  // decode on rising edge; unmapped count gives normal
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sel <= SEL_RST;
    else if (!pgSync)
      sel <= SEL_RST;
    else if (rtcRise && pgSync)
      sel <= btms_decode(lowCount);
  end

  assign testMode = sel.mode;

  // ----------------------------------------------------------------
  // xor chains
  // ----------------------------------------------------------------
  // inverted parity of member inputs per chain
  genvar g;
  generate
    for (g = 0; g < NUM_CHAINS; g++)
    begin : g_chain
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          parity[g] <= 1'b1;
        else
          parity[g] <= ~^(padSync & CHAIN_MASK[g] &
                          ~(NPINS'(1) << CHAIN_OUT[g]));
      end
    end
  endgenerate

  // one-hot of the selected chain output pin
  assign outOneHot = NPINS'(1) << CHAIN_OUT[sel.chainIdx];

  // ----------------------------------------------------------------
  // pad muxing
  // ----------------------------------------------------------------
  // float all in all-z; chain drives only its output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padOut <= '0;
      padOe  <= '0;
    end
    else if (sel.mode == BTMS_ALLZ)
    begin
      padOut <= '0;
      padOe  <= '0;
    end
    else if (sel.chainOn)
    begin
      padOut <= parity[sel.chainIdx] ? outOneHot : '0;
      padOe  <= outOneHot;
    end
    else
    begin
      padOut <= coreOut;
      padOe  <= coreOe;
    end
  end

  // chain one result on test point zero, driven in chain one only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      test_point_zero <= 1'b0;
    else
      test_point_zero <= (sel.mode == BTMS_XOR1) & parity[0];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_count_up;
    countEn && pgSync && !rtcRise && lowCount != CNT_MAX
      |=> lowCount == $past(lowCount) + 6'h01;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("low count did not advance");

  property p_count_sat;
    lowCount == CNT_MAX && countEn |=> lowCount == CNT_MAX;
  endproperty
  a_count_sat: assert property (p_count_sat)
    else $error("low count wrapped");

  property p_count_clr;
    !pgSync || rtcRise |=> lowCount == CNT_RST;
  endproperty
  a_count_clr: assert property (p_count_clr)
    else $error("low count not cleared");

  property p_decode;
    rtcRise && pgSync |=> sel == btms_decode($past(lowCount));
  endproperty
  a_decode: assert property (p_decode)
    else $error("mode not decoded from count");

  property p_unmapped;
    rtcRise && pgSync && (lowCount < CNT_XOR1 ||
      (lowCount > CNT_ALLZ && lowCount < CNT_XOR6) ||
      lowCount > CNT_XOR4BG) |=> testMode == BTMS_NORMAL;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped count left a test mode");

  property p_hold;
    !rtcRise && pgSync |=> $stable(sel);
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode changed without rising edge");

  property p_allz;
    sel.mode == BTMS_ALLZ ##1 sel.mode == BTMS_ALLZ |-> padOe == '0;
  endproperty
  a_allz: assert property (p_allz)
    else $error("pin driven in all-z mode");

  property p_chain_oe;
    sel.chainOn ##1 $stable(sel) |-> padOe == outOneHot;
  endproperty
  a_chain_oe: assert property (p_chain_oe)
    else $error("chain mode drives a wrong pin");

  property p_parity;
    sel.chainOn ##1 $stable(sel) ##1 $stable(sel)
      |-> (|(padOut & outOneHot)) ==
          ~^($past(padSync, 2) & CHAIN_MASK[sel.chainIdx] & ~outOneHot);
  endproperty
  a_parity: assert property (p_parity)
    else $error("chain output parity wrong");

  property p_normal;
    sel.mode == BTMS_NORMAL |=> padOe == $past(coreOe);
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal mode pads not from core");

  property p_no_count;
    !countEn && !rtcRise && pgSync |=> $stable(lowCount);
  endproperty
  a_no_count: assert property (p_no_count)
    else $error("low count moved while not counting");

  property p_pg_low;
    !pgSync |=> sel == SEL_RST;
  endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("test mode kept without power good");

  property p_one_chain;
    sel.chainOn |=> $onehot0(padOe);
  endproperty
  a_one_chain: assert property (p_one_chain)
    else $error("more than one chain output driven");

  property p_member_in;
    sel.chainOn ##1 $stable(sel)
      |-> (padOe & CHAIN_MASK[sel.chainIdx] & ~outOneHot) == '0;
  endproperty
  a_member_in: assert property (p_member_in)
    else $error("chain member pin driven");

  property p_tp0;
    sel.mode == BTMS_XOR1 |=> test_point_zero ==
      ~^($past(padSync, 2) & CHAIN_MASK[0] & ~(NPINS'(1) << CHAIN_OUT[0]));
  endproperty
  a_tp0: assert property (p_tp0)
    else $error("test point zero parity wrong");

  property p_tp0_off;
    sel.mode != BTMS_XOR1 |=> !test_point_zero;
  endproperty
  a_tp0_off: assert property (p_tp0_off)
    else $error("test point zero driven outside chain one");

endmodule // btms_core

// [core/btms_pkg.sv]
// btms_pkg: constants and types for board test mode selection
// assumes: one pci clock domain; pins reach the block through pad muxes
package btms_pkg;

  // ----------------------------------------------------------------
  // low-time count decode points
  // ----------------------------------------------------------------
  localparam int            CNT_W        = 6;
  localparam logic [5:0]    CNT_RST      = 6'h00;
  localparam logic [5:0]    CNT_MAX      = 6'h3F; // saturation ceiling
  localparam logic [5:0]    CNT_XOR1     = 6'h04;
  localparam logic [5:0]    CNT_XOR2     = 6'h05;
  localparam logic [5:0]    CNT_XOR3     = 6'h06;
  localparam logic [5:0]    CNT_XOR4     = 6'h07;
  localparam logic [5:0]    CNT_ALLZ     = 6'h08;
  localparam logic [5:0]    CNT_XOR6     = 6'h34; // 52
  localparam logic [5:0]    CNT_XOR4BG   = 6'h35; // 53

  // ----------------------------------------------------------------
  // chain slots
  // ----------------------------------------------------------------
  localparam int            NUM_CHAINS   = 6;
  localparam int            PIN_IDX_W    = 6;
  localparam int            NUM_PINS     = 64;

  typedef enum logic [3:0] {
    BTMS_NORMAL,
    BTMS_XOR1,
    BTMS_XOR2,
    BTMS_XOR3,
    BTMS_XOR4,
    BTMS_ALLZ,
    BTMS_XOR6,
    BTMS_XOR4BG
  } btms_mode_t;

  // selected mode with chain slot and chain flag
  typedef struct packed {
    logic       chainOn;
    logic [2:0] chainIdx;
    btms_mode_t mode;
  } btms_sel_t;

  localparam btms_sel_t SEL_RST = '{1'b0, 3'h0, BTMS_NORMAL};

  // count to mode; unmapped counts mean normal operation
  function automatic btms_sel_t btms_decode(input logic [5:0] cnt);
    btms_sel_t s;
    s = SEL_RST;
    unique case (cnt)
      CNT_XOR1:   s = '{1'b1, 3'h0, BTMS_XOR1};
      CNT_XOR2:   s = '{1'b1, 3'h1, BTMS_XOR2};
      CNT_XOR3:   s = '{1'b1, 3'h2, BTMS_XOR3};
      CNT_XOR4:   s = '{1'b1, 3'h3, BTMS_XOR4};
      CNT_ALLZ:   s = '{1'b0, 3'h0, BTMS_ALLZ};
      CNT_XOR6:   s = '{1'b1, 3'h4, BTMS_XOR6};
      CNT_XOR4BG: s = '{1'b1, 3'h5, BTMS_XOR4BG};
      default:    s = SEL_RST;
    endcase
    return s;
  endfunction

endpackage

// [sim/btms_ate_model.sv]
// btms_ate_model: board tester driving selection pin, power good, pins
// assumes: pci clock from the bench; changes its lines on falling edges
`timescale 1ns/10ps
module btms_ate_model
(
  input  wire logic        clk,
  input  wire logic        hostRstN,
  output logic             rtcN,
  output logic             pg,
  output logic [63:0]      pins
);
  // ----------------------------------------------------------------
  // idle levels and selection pulse
  // ----------------------------------------------------------------
  initial
  begin
    rtcN = 1'b1;
    pg   = 1'b1;
    pins = 64'h0;
  end

  // low pulse of n clocks; a new pulse replaces the mode
  task automatic pulse(input int n);
    @(negedge clk);
    while (hostRstN !== 1'b1) @(negedge clk);
    if (n >= 9 && n <= 42) n = 3; // counts 9 to 42 never sent, 3 instead
    rtcN = 1'b0;
    repeat (n) @(negedge clk);
    rtcN = 1'b1;
  endtask
endmodule // btms_ate_model

// [sim/board_test_mode_select_tb_top.sv]
// board_test_mode_select_tb_top: mode selection and chain checks
// assumes: default chain masks; tester model drives selection and pins
`timescale 1ns/10ps
module board_test_mode_select_tb_top;
  import btms_pkg::*;
  logic        clk, rst_n, hostRstN, rtcN, pg, tp0;
  logic [63:0] pins, coreOut, coreOe, padOut, padOe;
  btms_mode_t  testMode, lastMode;
  btms_mode_t  expQ[$];
  int          failures, checks, cycles;
  int          counts[14] = '{4, 70, 5, 6, 7, 8, 3, 52, 43, 53, 51, 4, 54, 7};
  int          loT[8] = '{0, 0, 8, 16, 24, 0, 48, 32};
  int          opT[8] = '{0, 8, 16, 24, 32, 0, 56, 40};

  // ----------------------------------------------------------------
  // design, tester, clock
  // ----------------------------------------------------------------
  btms_core dut (.clk(clk), .rst_n(rst_n), .rtc_domain_reset_n(rtcN),
    .core_power_good(pg), .host_bus_reset_out_n(hostRstN), .padIn(pins),
    .coreOut(coreOut), .coreOe(coreOe), .padOut(padOut), .padOe(padOe),
    .testMode(testMode), .test_point_zero(tp0));
  btms_ate_model ate (.clk(clk), .hostRstN(hostRstN), .rtcN(rtcN),
    .pg(pg), .pins(pins));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // low count to expected mode
  function automatic btms_mode_t modeOf(input int n);
    case (n)
      4: return BTMS_XOR1;
      5: return BTMS_XOR2;
      6: return BTMS_XOR3;
      7: return BTMS_XOR4;
      8: return BTMS_ALLZ;
      52: return BTMS_XOR6;
      53: return BTMS_XOR4BG;
      default: return BTMS_NORMAL;
    endcase
  endfunction

  // random pins and core drive, then pad and parity checks
  task automatic checkPads(input btms_mode_t m);
    int lo, op;
    lo = loT[m];
    op = opT[m];
    ate.pins = {$urandom, $urandom};
    coreOut = {$urandom, $urandom};
    coreOe = {$urandom, $urandom};
    repeat (6) @(negedge clk);
    case (m)
      BTMS_NORMAL:
      begin
        check(padOe, coreOe);
        check(padOut, coreOut);
      end
      BTMS_ALLZ: check(padOe, 64'h0);
      default:
      begin
        check(padOe, 64'h1 << op);
        check(padOut[op], ~^pins[lo+:8]);
      end
    endcase
    if (m == BTMS_XOR1)
      check(tp0, ~^pins[7:0]);
    else
      check(tp0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // monitor, timeout, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    lastMode = BTMS_NORMAL;
    forever
    begin
      @(negedge clk);
      if (testMode !== lastMode)
      begin
        lastMode = testMode;
        if (expQ.size() == 0)
          check(1, 0);
        else
          check(testMode, expQ.pop_front());
      end
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      finish_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    hostRstN = 1'b1;
    coreOut = 64'h0;
    coreOe = 64'h0;
    void'($urandom(60443));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (counts[i])
    begin
      expQ.push_back(modeOf(counts[i]));
      ate.pulse(counts[i]);
      repeat (8) @(negedge clk);
      checkPads(modeOf(counts[i]));
    end
    // pulse while power is not good is not counted
    expQ.push_back(BTMS_NORMAL);
    ate.pg = 1'b0;
    ate.pulse(4);
    ate.pg = 1'b1;
    repeat (8) @(negedge clk);
    check(testMode, BTMS_NORMAL);
    // bus reset held: tester waits for its release
    hostRstN = 1'b0;
    fork
      begin
        repeat (20) @(negedge clk);
        hostRstN = 1'b1;
      end
    join_none
    expQ.push_back(BTMS_XOR2);
    ate.pulse(5);
    repeat (8) @(negedge clk);
    checkPads(BTMS_XOR2);
    check(expQ.size(), 0);
    finish_test();
  end
endmodule // board_test_mode_select_tb_top
